/* File: include/kpd_consts.svh */
// Offsets, field positions and reset values of the keypad level interrupt unit
`ifndef KPD_CONSTS_SVH
`define KPD_CONSTS_SVH

// Number of sense inputs and drive outputs
`define KPD_NUM_IN 4

// Register indexes; the APB byte address is four times the index
`define KPD_IDX_LEVEL 10'h08d
`define KPD_IDX_ENABLE 10'h08e
`define KPD_IDX_FLAGS 10'h08f
`define KPD_IDX_CTRL 10'h090
`define KPD_IDX_DRIVE 10'h091
`define KPD_IDX_IRQ_STAT 10'h092
`define KPD_IDX_IRQ_MASK 10'h093
`define KPD_ADDR_W 12

// Field positions
`define KPD_CTRL_GEN_BIT 0
`define KPD_FIELD_MSB 3

// Reset values
`define KPD_RST_NIB 4'h0
`define KPD_RST_WORD 32'h0000_0000

`endif

/* File: include/kpd_pkg.sv */
// Types shared by the keypad level interrupt unit
`include "kpd_consts.svh"

package kpd_pkg;

    // One-hot register select decoded from the APB address
    typedef enum logic [7:0] {
        KPD_SEL_LEVEL = 8'b0000_0001,
        KPD_SEL_ENABLE = 8'b0000_0010,
        KPD_SEL_FLAGS = 8'b0000_0100,
        KPD_SEL_CTRL = 8'b0000_1000,
        KPD_SEL_DRIVE = 8'b0001_0000,
        KPD_SEL_STAT = 8'b0010_0000,
        KPD_SEL_MASK = 8'b0100_0000,
        KPD_SEL_NONE = 8'b1000_0000
    } kpd_sel_e;

    typedef logic [`KPD_NUM_IN-1:0] kpd_nib_t;

    // State of one sense cell
    typedef struct packed {
        logic flag;
    } kpd_cell_s;

    // State of the interrupt status and mask bank
    typedef struct packed {
        kpd_nib_t status;
        kpd_nib_t mask;
        logic irq;
    } kpd_irq_s;

    // State of the top level
    typedef struct packed {
        kpd_nib_t level;
        kpd_nib_t enable;
        logic gen;
        kpd_nib_t drive;
        kpd_nib_t req_prev;
        logic kirq;
        logic wake;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } kpd_top_s;

endpackage : kpd_pkg

/* File: rtl/kpd_sense_cell.sv */
// One keypad sense input: level match and sticky event flag
`timescale 1ns/10ps
`default_nettype none

module kpd_sense_cell
    import kpd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic sense_i,
    input wire logic level_sel_i,
    input wire logic clear_i,
    output logic hit_o,
    output logic flag_o
);

    kpd_cell_s s_q;
    kpd_cell_s s_d;

    // Selected level: low when the select bit is 0, high when it is 1
    assign hit_o = (sense_i == level_sel_i);

    // Setting wins over the software clear, so a held level re-flags at once
    always_comb begin
        s_d = s_q;
        s_d.flag = (s_q.flag & ~clear_i) | hit_o;
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag_o = s_q.flag;

endmodule : kpd_sense_cell

`default_nettype wire

/* File: rtl/kpd_irq_bank.sv */
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/10ps
`default_nettype none

module kpd_irq_bank
    import kpd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire kpd_nib_t event_i,
    input wire logic clr_wr_i,
    input wire logic mask_wr_i,
    input wire kpd_nib_t wdata_i,
    output kpd_nib_t status_o,
    output kpd_nib_t mask_o,
    output logic irq_o
);

    kpd_irq_s s_q;
    kpd_irq_s s_d;

    // An event in the clearing cycle survives: set beats clear
    always_comb begin
        s_d = s_q;
        if (clr_wr_i) begin
            s_d.status = s_q.status & ~wdata_i;
        end
        s_d.status = s_d.status | event_i;
        if (mask_wr_i) begin
            s_d.mask = wdata_i;
        end
        // Built from next values so the output follows status without lag
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_o = s_q.status;
    assign mask_o = s_q.mask;
    assign irq_o = s_q.irq;

endmodule : kpd_irq_bank

`default_nettype wire

/* File: rtl/kpd_level_irq_unit.sv */
// Keypad level interrupt unit: APB registers, sense cells, wake and interrupt
//
// Behaviour
// - Four keypad sense inputs and four drive outputs scan a 4x4 switch matrix.
// - Each sense input is its own source; all four share one request.
// - Clearing the global enable blocks the shared keypad request entirely.
// - Level-select bit 0 detects low, bit 1 detects high on that input.
// - Flag bit n sets whenever input n sits at its selected level.
// - A set flag requests an interrupt only while its enable bit is one.
// - Any write to the flag register with byte lane 0 strobed clears at once each flag whose input is off its selected level.
// - With its enable bit zero a pin is plain GPIO, no keypad request.
// - Active level on an enabled input wakes the chip from deep sleep.
`timescale 1ns/10ps
`default_nettype none

module kpd_level_irq_unit
    import kpd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`KPD_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire kpd_nib_t keypad_sense_input_i,
    output kpd_nib_t keypad_drive_o,
    output kpd_nib_t keypad_func_o,
    output logic keypad_irq_o,
    output logic wake_o,
    output logic irq_o
);

    kpd_top_s s_q;
    kpd_top_s s_d;
    kpd_sel_e sel;
    kpd_nib_t hit_w;
    kpd_nib_t flags_w;
    kpd_nib_t req_w;
    kpd_nib_t stat_w;
    kpd_nib_t mask_w;
    kpd_nib_t wnib;
    logic setup_w;
    logic wr_w;
    logic wr_flags;
    logic wr_ctrl;
    logic irq_w;

    // Address decode to a one-hot select; anything else is unmapped
    always_comb begin
        sel = KPD_SEL_NONE;
        if (paddr_i[1:0] == 2'b00) begin
            case (paddr_i[`KPD_ADDR_W-1:2])
                `KPD_IDX_LEVEL: sel = KPD_SEL_LEVEL;
                `KPD_IDX_ENABLE: sel = KPD_SEL_ENABLE;
                `KPD_IDX_FLAGS: sel = KPD_SEL_FLAGS;
                `KPD_IDX_CTRL: sel = KPD_SEL_CTRL;
                `KPD_IDX_DRIVE: sel = KPD_SEL_DRIVE;
                `KPD_IDX_IRQ_STAT: sel = KPD_SEL_STAT;
                `KPD_IDX_IRQ_MASK: sel = KPD_SEL_MASK;
                default: sel = KPD_SEL_NONE;
            endcase
        end
    end

    // Writes land at the access edge, only with byte lane 0 strobed
    assign setup_w = psel_i & ~penable_i;
    assign wr_w = psel_i & penable_i & pwrite_i & s_q.pready & pstrb_i[0];
    assign wr_flags = wr_w & (sel == KPD_SEL_FLAGS);
    assign wr_ctrl = wr_w & (sel == KPD_SEL_CTRL);
    // Write data above the low nibble is dropped so reserved bits stay zero
    assign wnib = pwdata_i[`KPD_FIELD_MSB:0];

    // One sense cell per input, each its own interrupt source
    genvar gi;
    generate
        for (gi = 0; gi < `KPD_NUM_IN; gi++) begin : g_cell
            kpd_sense_cell u_cell (
                .mclk_i(mclk_i),
                .resetn_i(resetn_i),
                .sense_i(keypad_sense_input_i[gi]),
                .level_sel_i(s_q.level[gi]),
                .clear_i(wr_flags),
                .hit_o(hit_w[gi]),
                .flag_o(flags_w[gi])
            );
        end
    endgenerate

    // Per-input request: flag gated by its enable and the global enable
    assign req_w = flags_w & s_q.enable & {`KPD_NUM_IN{s_q.gen}};

    // New requests become sticky status events for the masked interrupt
    kpd_irq_bank u_irq (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .event_i(req_w & ~s_q.req_prev),
        .clr_wr_i(wr_w & (sel == KPD_SEL_STAT)),
        .mask_wr_i(wr_w & (sel == KPD_SEL_MASK)),
        .wdata_i(wnib),
        .status_o(stat_w),
        .mask_o(mask_w),
        .irq_o(irq_w)
    );

    // Next state: register writes, request, wake and APB answer
    always_comb begin
        s_d = s_q;
        s_d.req_prev = req_w;
        // All four sources fold onto the one shared request
        s_d.kirq = |req_w;
        // Wake needs no global enable; it only looks at enabled inputs
        s_d.wake = |(hit_w & s_q.enable);
        // Zero wait states: ready in the access cycle, low otherwise
        s_d.pready = setup_w;
        s_d.pslverr = setup_w & (sel == KPD_SEL_NONE);
        if (wr_w) begin
            unique case (sel)
                KPD_SEL_LEVEL: s_d.level = wnib;
                KPD_SEL_ENABLE: s_d.enable = wnib;
                KPD_SEL_CTRL: s_d.gen = pwdata_i[`KPD_CTRL_GEN_BIT];
                KPD_SEL_DRIVE: s_d.drive = wnib;
                KPD_SEL_FLAGS, KPD_SEL_STAT, KPD_SEL_MASK, KPD_SEL_NONE: s_d.level = s_q.level;
            endcase
        end
        // Read data is sampled in the setup cycle; upper bits always zero
        if (setup_w) begin
            s_d.prdata = `KPD_RST_WORD;
            unique case (sel)
                KPD_SEL_LEVEL: s_d.prdata[`KPD_FIELD_MSB:0] = s_q.level;
                KPD_SEL_ENABLE: s_d.prdata[`KPD_FIELD_MSB:0] = s_q.enable;
                KPD_SEL_FLAGS: s_d.prdata[`KPD_FIELD_MSB:0] = flags_w;
                KPD_SEL_CTRL: s_d.prdata[`KPD_CTRL_GEN_BIT] = s_q.gen;
                KPD_SEL_DRIVE: s_d.prdata[`KPD_FIELD_MSB:0] = s_q.drive;
                KPD_SEL_STAT: s_d.prdata[`KPD_FIELD_MSB:0] = stat_w;
                KPD_SEL_MASK: s_d.prdata[`KPD_FIELD_MSB:0] = mask_w;
                KPD_SEL_NONE: s_d.prdata = `KPD_RST_WORD;
            endcase
        end
    end

    // Synchronous reset: every control field starts at zero
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_q.level <= `KPD_RST_NIB;
            s_q.enable <= `KPD_RST_NIB;
            s_q.gen <= 1'b0;
            s_q.drive <= `KPD_RST_NIB;
            s_q.req_prev <= `KPD_RST_NIB;
            s_q.kirq <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= `KPD_RST_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign keypad_drive_o = s_q.drive;
    // High selects keypad function, low leaves the pin as plain GPIO
    assign keypad_func_o = s_q.enable;
    assign keypad_irq_o = s_q.kirq;
    assign wake_o = s_q.wake;
    assign irq_o = irq_w;

    // Checks on the design's own behaviour
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence

    sequence s_access_done;
        pready_o ##1 !pready_o;
    endsequence

    sequence s_flag_write;
        wr_flags && (hit_w == 4'h0);
    endsequence

    // A matching level shows up in the flags on the next edge
    // Guarded by reset: attempts at the release edge still sample the state from before reset
    property p_flag_set;
        resetn_i && (hit_w != 4'h0) |=> ((flags_w & $past(hit_w)) == $past(hit_w));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag missed an active level");

    // A flag never rises without its input at the selected level
    property p_flag_cause;
        1'b1 |=> ((flags_w & ~$past(flags_w) & ~$past(hit_w)) == 4'h0);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag rose with no active level");

    // A flag write with no active level empties the register
    property p_flag_clear;
        s_flag_write |=> (flags_w == 4'h0);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag write left a bit set");

    // A held level refills the flag right after a clearing write
    property p_flag_refill;
        wr_flags && (hit_w != 4'h0) |=> ((flags_w & $past(hit_w)) == $past(hit_w));
    endproperty
    a_flag_refill: assert property (p_flag_refill) else $error("held level not re-flagged");

    // Global enable low keeps the shared request low
    property p_global_block;
        !s_q.gen && !wr_ctrl |=> !keypad_irq_o ##1 (!keypad_irq_o || $past(s_q.gen));
    endproperty
    a_global_block: assert property (p_global_block) else $error("request passed global disable");

    // The shared request rises only from an enabled, set flag
    property p_req_cause;
        $rose(keypad_irq_o) |-> $past(s_q.gen && ((flags_w & s_q.enable) != 4'h0));
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without enabled flag");

    // Flags on disabled inputs only never request
    property p_gpio_quiet;
        ((flags_w & s_q.enable) == 4'h0) |=> !keypad_irq_o;
    endproperty
    a_gpio_quiet: assert property (p_gpio_quiet) else $error("disabled input raised request");

    // An active level on an enabled input wakes on the next edge
    // Same reset guard: wake is cleared at the release edge whatever the pins show
    property p_wake;
        resetn_i && ((hit_w & s_q.enable) != 4'h0) |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("enabled level did not wake");

    // Every read keeps reserved bits at zero
    property p_read_upper;
        s_setup |=> (prdata_o[31:4] == 28'h0);
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("reserved read bits not zero");

    // Ready answers the access cycle and then drops
    property p_apb_ready;
        s_setup |=> s_access_done;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("pready not one access cycle");

    // Interrupt output only with an unmasked status bit
    property p_irq_out;
        irq_o |-> ((stat_w & mask_w) != 4'h0);
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq without unmasked status");

    // A flag stays set until software writes the flag register
    property p_flag_hold;
        resetn_i && !wr_flags |=> ((flags_w & $past(flags_w)) == $past(flags_w));
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clearing write");

    // A level-select write lands at the access edge
    property p_level_write;
        wr_w && (sel == KPD_SEL_LEVEL) |=> (s_q.level == $past(wnib));
    endproperty
    a_level_write: assert property (p_level_write) else $error("level select write lost");

    // An enable write shows on the function outputs one edge later
    property p_enable_write;
        wr_w && (sel == KPD_SEL_ENABLE) |=> (keypad_func_o == $past(wnib));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    // The global enable bit follows a control write
    property p_ctrl_write;
        wr_ctrl |=> (s_q.gen == $past(pwdata_i[`KPD_CTRL_GEN_BIT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("global enable write lost");

    // A drive write reaches the matrix drive pins
    property p_drive_write;
        wr_w && (sel == KPD_SEL_DRIVE) |=> (keypad_drive_o == $past(wnib));
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("drive write lost");

    // Any enabled, globally allowed flag raises the shared request
    property p_req_follow;
        resetn_i && (req_w != 4'h0) |=> keypad_irq_o;
    endproperty
    a_req_follow: assert property (p_req_follow) else $error("enabled flag gave no request");

    // A newly rising per-input request lands in the sticky status
    property p_stat_set;
        resetn_i && ((req_w & ~s_q.req_prev) != 4'h0) |=>
            ((stat_w & $past(req_w & ~s_q.req_prev)) == $past(req_w & ~s_q.req_prev));
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("new request missing from status");

    // Unmapped addresses answer with an error and zero data
    property p_unmapped;
        psel_i && !penable_i && (sel == KPD_SEL_NONE) |=> pslverr_o && (prdata_o == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

endmodule : kpd_level_irq_unit

`default_nettype wire

/* File: testbench/kpd_keypad_model.sv */
// Behavioural 4x4 switch matrix that sits on the keypad pins
`timescale 1ns/10ps
`default_nettype none

module kpd_keypad_model (
    input wire logic [3:0] drive_i,
    input wire logic [15:0] press_i,
    output logic [3:0] sense_o
);
    // Rows have pull-ups; a closed switch pulls its row low only while its column is driven low
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            sense_o[r] = 1'b1;
            for (int c = 0; c < 4; c++) begin
                if (press_i[r*4+c] && !drive_i[c]) begin
                    sense_o[r] = 1'b0;
                end
            end
        end
    end
endmodule : kpd_keypad_model
`default_nettype wire

/* File: testbench/test_keypad_level_interrupt_unit.sv */
// Self-checking bench with a cycle model of the keypad level interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "kpd_consts.svh"

module test_keypad_level_interrupt_unit
    import kpd_pkg::*;
;
    localparam logic [11:0] A_LVL = {`KPD_IDX_LEVEL, 2'b00};
    localparam logic [11:0] A_EN = {`KPD_IDX_ENABLE, 2'b00};
    localparam logic [11:0] A_FLG = {`KPD_IDX_FLAGS, 2'b00};
    localparam logic [11:0] A_CTL = {`KPD_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_DRV = {`KPD_IDX_DRIVE, 2'b00};
    localparam logic [11:0] A_STA = {`KPD_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MSK = {`KPD_IDX_IRQ_MASK, 2'b00};
    logic mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o;
    logic [3:0] pstrb_i = '0, sense, drv_o, func_o;
    logic [15:0] press = '0;
    logic pready_o, pslverr_o, kirq_o, wake_o, irq_o, wr;
    int bad_count = 0, checks = 0;
    // Model state
    logic [3:0] lvl_q, en_q, flg_q, drv_q, sta_q, msk_q, reqp_q, hit, req;
    logic gen_q, kirq_q, wake_q;

    kpd_level_irq_unit kpd_level_irq_unit_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .keypad_sense_input_i(sense),
        .keypad_drive_o(drv_o), .keypad_func_o(func_o), .keypad_irq_o(kirq_o), .wake_o(wake_o), .irq_o(irq_o));
    kpd_keypad_model kpd_keypad_model_inst (.drive_i(drv_o), .press_i(press), .sense_o(sense));

    always #12.5 mclk_i = ~mclk_i;

    // Reference model; writes land at the edge closing the access cycle, zero wait states
    // Model strobe, level matches and requests, as they stand before each edge
    always_comb begin
        wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
        hit = ~(sense ^ lvl_q);
        req = flg_q & en_q & {4{gen_q}};
    end

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            {lvl_q, en_q, flg_q, drv_q, sta_q, msk_q, reqp_q, gen_q, kirq_q, wake_q} <= '0;
        end else begin
            flg_q <= ((wr && paddr_i == A_FLG) ? 4'h0 : flg_q) | hit;
            kirq_q <= |req;
            wake_q <= |(hit & en_q);
            reqp_q <= req;
            sta_q <= (sta_q & ~((wr && paddr_i == A_STA) ? pwdata_i[3:0] : 4'h0)) | (req & ~reqp_q);
            if (wr && paddr_i == A_LVL) lvl_q <= pwdata_i[3:0];
            if (wr && paddr_i == A_EN) en_q <= pwdata_i[3:0];
            if (wr && paddr_i == A_CTL) gen_q <= pwdata_i[0];
            if (wr && paddr_i == A_DRV) drv_q <= pwdata_i[3:0];
            if (wr && paddr_i == A_MSK) msk_q <= pwdata_i[3:0];
        end
    end

    function automatic logic [31:0] mread(input logic [11:0] a);
        case (a)
            A_LVL: return {28'h0, lvl_q};
            A_EN: return {28'h0, en_q};
            A_FLG: return {28'h0, flg_q};
            A_CTL: return {31'h0, gen_q};
            A_DRV: return {28'h0, drv_q};
            A_STA: return {28'h0, sta_q};
            A_MSK: return {28'h0, msk_q};
            default: return 32'h0;
        endcase
    endfunction : mread

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; read data is expected as the registers stood in the setup cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] exp;
        logic err;
        int n;
        @(posedge mclk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        #1;
        exp = mread(a);
        err = (a < A_LVL) || (a > A_MSK) || (a[1:0] != 2'b00);
        @(posedge mclk_i);
        penable_i <= 1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) bad_count++;
        if (!w) chk(prdata_o, exp);
        chk({31'h0, pslverr_o}, {31'h0, err});
        psel_i <= 0;
        penable_i <= 0;
    endtask : apb

    // Pin-side outputs compared every cycle, away from the sampling edge
    always @(negedge mclk_i) begin
        if (resetn_i) begin
            chk({31'h0, kirq_o}, {31'h0, kirq_q});
            chk({31'h0, wake_o}, {31'h0, wake_q});
            chk({31'h0, irq_o}, {31'h0, |(sta_q & msk_q)});
            chk({28'h0, func_o}, {28'h0, en_q});
            chk({28'h0, drv_o}, {28'h0, drv_q});
        end
    end

    task automatic read_all();
        apb(0, A_LVL, 0, 0);
        apb(0, A_EN, 0, 0);
        apb(0, A_FLG, 0, 0);
        apb(0, A_CTL, 0, 0);
        apb(0, A_DRV, 0, 0);
        apb(0, A_STA, 0, 0);
        apb(0, A_MSK, 0, 0);
        apb(0, 12'h250, 0, 0);
        apb(1, 12'h235, 32'hffff_ffff, 4'hf);
    endtask : read_all

    task automatic end_sim();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Watchdog at 20000 cycles, far beyond the roughly 1500 cycles the sequence needs
    initial begin
        #(25 * 20000);
        bad_count++;
        end_sim();
    end

    // Main sequence: reset values, random traffic with key presses, then a reset mid-run
    initial begin
        void'($urandom(96));
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1;
        read_all();
        for (int i = 0; i < 40; i++) begin
            apb(1, A_LVL, $urandom, 4'hf);
            apb(1, A_EN, $urandom, 4'($urandom));
            apb(1, A_CTL, $urandom, 4'hf);
            apb(1, A_DRV, $urandom, 4'hf);
            apb(1, A_MSK, $urandom, 4'hf);
            press <= 16'($urandom);
            repeat (1 + $urandom % 4) @(posedge mclk_i);
            apb(0, A_FLG, 0, 0);
            apb(1, A_FLG, $urandom, 4'h1);
            apb(0, A_FLG, 0, 0);
            apb(0, A_STA, 0, 0);
            apb(1, A_STA, $urandom, 4'hf);
            apb(0, A_STA, 0, 0);
        end
        @(posedge mclk_i);
        resetn_i <= 0;
        @(posedge mclk_i);
        resetn_i <= 1;
        read_all();
        end_sim();
    end
endmodule : test_keypad_level_interrupt_unit
`default_nettype wire
